/* File: verilog/uart_pkg.sv */
// Constants shared by the serial transceiver, its FIFOs and its tick generator.
// Assumes one 40 MHz core clock and control strobes from logic on that clock.
// Overview of operation
// - Transmit and receive enables set after reset.
// - Disable mid-character finishes that character first.
// - Send start, data LSB first, parity, stops.
// - Receiver stores error flags with each byte.
// - Divisor: 16-bit integer, 6-bit fraction.
// - Tick at 16x baud; bit per 16 ticks.
// - Divisor and line control commit on line write.
// - Sixteen-entry FIFOs; read 12 bits, write 8.
// - Enabled transmitter drains FIFO back to back.
// - Busy while FIFO non-empty or shifter active.
// - Start valid only if low at tick eight.
// - Sample data every sixteen ticks, then parity.
// - Stop sample must be high, else framing.
// - FIFOs one deep until FIFO enable set.
// - Empty, full flags and overrun status exposed.
// - Trigger levels in eighths, default one half.
// - Seven events ORed into one request.
// - Masked status equals raw AND mask.
// - Clear write clears raw and masked views.
// - Timeout after 32 idle bit periods.
// - Loopback feeds transmit line to receiver.
// - Full receive FIFO drops byte, flags overrun.
package uart_pkg;
  localparam int          CLK_HZ        = 40_000_000;  // Core clock rate.
  localparam int          FIFO_DEPTH    = 16;          // Entries per FIFO.
  localparam int          PTR_W         = 4;           // FIFO pointer width.
  localparam int          CNT_W         = 5;           // FIFO fill count width.
  localparam int          RXW_W         = 12;          // Data plus four error flags.
  localparam int          DIVI_W        = 16;          // Integer divisor width.
  localparam int          DIVF_W        = 6;           // Fraction in sixty-fourths.
  localparam int          TICKS_PER_BIT = 16;          // Reference ticks per bit.
  localparam logic [3:0]  LAST_TICK     = 4'h000F;     // Final tick of a bit period.
  localparam logic [3:0]  START_TICK    = 4'h0007;     // Eighth tick, start check.
  localparam int          TOUT_BITS     = 32;          // Idle bit periods to timeout.
  localparam logic [9:0]  TOUT_TICKS    = 10'(TOUT_BITS * TICKS_PER_BIT - 1);
  // Line control field positions.
  localparam int          LC_BRK = 0;
  localparam int          LC_PEN = 1;
  localparam int          LC_EPS = 2;
  localparam int          LC_STP2 = 3;
  localparam int          LC_FEN = 4;
  localparam int          LC_WLEN = 5;                 // Two bits: length minus five.
  localparam int          LC_SPS = 7;
  localparam logic [7:0]  LC_RESET = 8'h0000;          // FIFOs off after reset.
  // Control field positions and reset value: both directions on, block off.
  localparam int          CT_EN  = 0;
  localparam int          CT_LBE = 1;
  localparam int          CT_TXE = 2;
  localparam int          CT_RXE = 3;
  localparam logic [3:0]  CT_RESET = 4'h000C;
  // Level select codes: 0..4 mean 1/8, 1/4, 1/2, 3/4, 7/8 of the FIFO.
  localparam logic [2:0]  LVL_HALF = 3'h0002;
  localparam logic [5:0]  IFLS_RESET = {LVL_HALF, LVL_HALF};
  // Event bit positions in raw, masked, mask and clear words.
  localparam int          EV_RX = 0;
  localparam int          EV_TX = 1;
  localparam int          EV_RT = 2;
  localparam int          EV_FE = 3;
  localparam int          EV_PE = 4;
  localparam int          EV_BE = 5;
  localparam int          EV_OE = 6;
  localparam int          EV_W  = 7;
  // Error flag positions above the data byte in a receive entry.
  localparam int          RX_FE = 8;
  localparam int          RX_PE = 9;
  localparam int          RX_BE = 10;
  localparam int          RX_OE = 11;
endpackage

/* File: verilog/fifo_if.sv */
// Push and pop signals of one FIFO, shared between the transceiver and its stores.
// Assumes both ends run on the core clock.
interface fifo_if #(parameter int W = 8);
  logic                        push;   // Write one entry.
  logic [W-1:0]                wdata;  // Entry to write.
  logic                        pop;    // Drop the head entry.
  logic [W-1:0]                rdata;  // Head entry.
  logic [uart_pkg::CNT_W-1:0]  count;  // Entries held.
  logic                        full;   // No room at current depth.
  logic                        empty;  // Nothing held.
  modport owner (output push, wdata, pop, input rdata, count, full, empty);
  modport store (input push, wdata, pop, output rdata, count, full, empty);
endinterface

/* File: verilog/uart_fifo.sv */
// Sixteen-entry FIFO that shrinks to a one-entry holding register when disabled.
// A push when full or a pop when empty is ignored; the transmit owner pushes unchecked.
module uart_fifo #(parameter int W = 8) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic DEEP,
  fifo_if.store     F
);
  logic [W-1:0]                mem [uart_pkg::FIFO_DEPTH];  // Entry storage.
  logic [uart_pkg::PTR_W-1:0]  wr_ff;                       // Write pointer.
  logic [uart_pkg::PTR_W-1:0]  rd_ff;                       // Read pointer.
  logic [uart_pkg::CNT_W-1:0]  cnt_ff;                      // Fill count.
  logic [uart_pkg::CNT_W-1:0]  limit;                       // Depth now in force.
  logic                        do_push;
  logic                        do_pop;

  // Depth follows the FIFO-enable bit; switching it with data held is not supported.
  assign limit   = DEEP ? uart_pkg::CNT_W'(uart_pkg::FIFO_DEPTH) : 5'h0001;
  assign F.full  = (cnt_ff >= limit);
  assign F.empty = (cnt_ff == 5'h0000);
  assign F.count = cnt_ff;
  assign F.rdata = mem[rd_ff];
  assign do_push = F.push && !F.full;
  assign do_pop  = F.pop && !F.empty;

  // Storage has no reset so it can map onto plain RAM.
  always_ff @(posedge CLK) begin
    if (do_push) begin
      mem[wr_ff] <= F.wdata;
    end
  end

  // Pointers and count.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= wr_ff + PTR_INC(do_push);
      rd_ff  <= rd_ff + PTR_INC(do_pop);
      cnt_ff <= cnt_ff + CNT_W5(do_push) - CNT_W5(do_pop);
    end
  end

  function automatic logic [uart_pkg::PTR_W-1:0] PTR_INC(input logic b);
    return {3'h0000, b};
  endfunction

  function automatic logic [uart_pkg::CNT_W-1:0] CNT_W5(input logic b);
    return {4'h0000, b};
  endfunction
endmodule

/* File: verilog/uart_tick_gen.sv */
// Reference tick generator at sixteen times the baud rate, fractional divisor.
// Assumes the divisor is stable between line-control writes; zero stops ticks.
module uart_tick_gen (
  input  wire logic                         CLK,
  input  wire logic                         RST_N,
  input  wire logic [uart_pkg::DIVI_W-1:0]  DIV_INT,
  input  wire logic [uart_pkg::DIVF_W-1:0]  DIV_FRAC,
  output logic                              TICK
);
  logic [uart_pkg::DIVI_W-1:0]  cnt_ff;   // Clocks left in this period.
  logic [uart_pkg::DIVF_W-1:0]  acc_ff;   // Fraction accumulator.
  logic [uart_pkg::DIVF_W:0]    acc_sum;  // Accumulator plus fraction, with carry.
  logic                         at_end;   // Last clock of the period.

  assign acc_sum = {1'b0, acc_ff} + {1'b0, DIV_FRAC};
  assign at_end  = (cnt_ff == '0) && (DIV_INT != '0);

  // Each period lasts the integer part, plus one clock when the fraction carries,
  // so the mean period is integer plus fraction over 64.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff <= '0;
      acc_ff <= '0;
      TICK   <= 1'b0;
    end else begin
      TICK <= at_end;
      if (at_end) begin
        acc_ff <= acc_sum[uart_pkg::DIVF_W-1:0];
        cnt_ff <= DIV_INT - 16'h0001 + {15'h0000, acc_sum[uart_pkg::DIVF_W]};
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end
endmodule

/* File: verilog/uart_top.sv */
// Asynchronous serial transceiver: control words, FIFOs, framing and events.
// Assumes control strobes come from logic on CORE_CLK; only the receive pin
// is asynchronous and is synchronised here.
module uart_top (
  input  wire logic         CORE_CLK,
  input  wire logic         RST_N,
  input  wire logic         SERIAL_RECEIVE_LINE,
  output logic              SERIAL_TRANSMIT_LINE,
  input  wire logic         INT_DIV_WR,
  input  wire logic [15:0]  INT_DIV_DATA,
  input  wire logic         FRAC_DIV_WR,
  input  wire logic [5:0]   FRAC_DIV_DATA,
  input  wire logic         LINE_CTRL_WR,
  input  wire logic [7:0]   LINE_CTRL_DATA,
  input  wire logic         CTRL_WR,
  input  wire logic [3:0]   CTRL_DATA,
  input  wire logic         LEVEL_SEL_WR,
  input  wire logic [5:0]   LEVEL_SEL_DATA,
  input  wire logic         MASK_WR,
  input  wire logic [6:0]   MASK_DATA,
  input  wire logic         EVENT_CLR_WR,
  input  wire logic [6:0]   EVENT_CLR_DATA,
  input  wire logic         TX_WR,
  input  wire logic [7:0]   TX_DATA,
  input  wire logic         RX_RD,
  input  wire logic         OVERRUN_CLR,
  output logic [11:0]       RX_DATA,
  output logic              BUSY,
  output logic              TX_EMPTY,
  output logic              TX_FULL,
  output logic              RX_EMPTY,
  output logic              RX_FULL,
  output logic              OVERRUN,
  output logic [6:0]        RAW_STATUS,
  output logic [6:0]        MASKED_STATUS,
  output logic              IRQ
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_START = 5'b00010, S_DATA = 5'b00100,
    S_PAR  = 5'b01000, S_STOP  = 5'b10000
  } ser_state_e;

  // Control words and the shadow halves of the divisor.
  logic [15:0]  int_sh_ff;    // Integer divisor waiting for commit.
  logic [5:0]   frac_sh_ff;   // Fraction waiting for commit.
  logic [15:0]  div_int_ff;   // Integer divisor in force.
  logic [5:0]   div_frac_ff;  // Fraction in force.
  logic [7:0]   lc_ff;        // Line control in force.
  logic [3:0]   ct_ff;        // Enable, loopback, transmit and receive enables.
  logic [5:0]   ifls_ff;      // Receive level in [5:3], transmit in [2:0].
  logic [6:0]   mask_ff;      // Event mask.
  logic [6:0]   raw_ff;       // Sticky raw events.
  logic [6:0]   nxt_raw;
  logic         tick;         // Sixteen-times reference tick.
  logic [1:0]   wlen;
  logic         en_tx;
  logic         en_rx;

  fifo_if #(.W(8))                  txf ();
  fifo_if #(.W(uart_pkg::RXW_W))    rxf ();

  uart_tick_gen u_tick (
    .CLK      (CORE_CLK),
    .RST_N    (RST_N),
    .DIV_INT  (div_int_ff),
    .DIV_FRAC (div_frac_ff),
    .TICK     (tick)
  );
  uart_fifo #(.W(8)) u_txf (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .DEEP  (lc_ff[uart_pkg::LC_FEN]),
    .F     (txf.store)
  );
  uart_fifo #(.W(uart_pkg::RXW_W)) u_rxf (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .DEEP  (lc_ff[uart_pkg::LC_FEN]),
    .F     (rxf.store)
  );

  assign wlen  = lc_ff[uart_pkg::LC_WLEN +: 2];
  assign en_tx = ct_ff[uart_pkg::CT_EN] && ct_ff[uart_pkg::CT_TXE];
  assign en_rx = ct_ff[uart_pkg::CT_EN] && ct_ff[uart_pkg::CT_RXE];

  // Parity over the active data bits; stick parity sends the inverse of even select.
  function automatic logic parity_of(input logic [7:0] d, input logic [1:0] wl,
                                     input logic eps, input logic sps);
    logic [7:0] m;
    m = d & (8'h00FF >> (2'h3 - wl));
    return sps ? !eps : (eps ? ^m : !(^m));
  endfunction

  // Trigger level in entries for a select code: eighths of sixteen.
  function automatic logic [4:0] level_of(input logic [2:0] sel);
    case (sel)
      3'h0000: level_of = 5'h0002;
      3'h0001: level_of = 5'h0004;
      3'h0003: level_of = 5'h000C;
      3'h0004: level_of = 5'h000E;
      default: level_of = 5'h0008;
    endcase
  endfunction

  // Control words. The divisor halves sit in shadows and reach the tick generator
  // only together with a line-control write, so a half-written divisor never runs.
  // Writing while enabled is tolerated but gives undefined framing.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_sh_ff   <= '0;
      frac_sh_ff  <= '0;
      div_int_ff  <= '0;
      div_frac_ff <= '0;
      lc_ff       <= uart_pkg::LC_RESET;
      ct_ff       <= uart_pkg::CT_RESET;
      ifls_ff     <= uart_pkg::IFLS_RESET;
      mask_ff     <= '0;
    end else begin
      if (INT_DIV_WR) int_sh_ff <= INT_DIV_DATA;
      if (FRAC_DIV_WR) frac_sh_ff <= FRAC_DIV_DATA;
      if (LINE_CTRL_WR) begin
        div_int_ff  <= INT_DIV_WR ? INT_DIV_DATA : int_sh_ff;
        div_frac_ff <= FRAC_DIV_WR ? FRAC_DIV_DATA : frac_sh_ff;
        lc_ff       <= LINE_CTRL_DATA;
      end
      if (CTRL_WR) ct_ff <= CTRL_DATA;
      if (LEVEL_SEL_WR) ifls_ff <= LEVEL_SEL_DATA;
      if (MASK_WR) mask_ff <= MASK_DATA;
    end
  end

  // Transmitter.
  ser_state_e  tx_st_ff;
  logic [3:0]  tx_tc_ff;    // Tick within bit.
  logic [2:0]  tx_bc_ff;    // Data bits left minus one.
  logic [7:0]  tx_sh_ff;    // Shifter.
  logic        tx_par_ff;   // Parity bit of this character.
  logic        tx_stop2_ff; // Second stop bit still owed.
  logic        tx_bit_end;
  logic        tx_go;
  logic        tx_bit;

  assign tx_bit_end = tick && (tx_tc_ff == uart_pkg::LAST_TICK);
  // A new character starts only while enabled; one in flight always completes.
  assign tx_go      = (tx_st_ff == S_IDLE) && en_tx && !txf.empty;
  assign txf.pop    = tx_go;
  assign txf.push   = TX_WR;
  assign txf.wdata  = TX_DATA;
  assign tx_bit     = (tx_st_ff == S_START) ? 1'b0 :
                      (tx_st_ff == S_DATA)  ? tx_sh_ff[0] :
                      (tx_st_ff == S_PAR)   ? tx_par_ff : 1'b1;

  // Frame sequencing: start, data from bit zero, optional parity, one or two stops.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_st_ff    <= S_IDLE;
      tx_tc_ff    <= '0;
      tx_bc_ff    <= '0;
      tx_sh_ff    <= '0;
      tx_par_ff   <= 1'b0;
      tx_stop2_ff <= 1'b0;
    end else begin
      if (tick) tx_tc_ff <= tx_tc_ff + 4'h0001;
      case (tx_st_ff)
        S_IDLE: if (tx_go) begin
          tx_st_ff  <= S_START;
          tx_tc_ff  <= '0;
          tx_sh_ff  <= txf.rdata;
          tx_par_ff <= parity_of(txf.rdata, wlen, lc_ff[uart_pkg::LC_EPS],
                                 lc_ff[uart_pkg::LC_SPS]);
        end
        S_START: if (tx_bit_end) begin
          tx_st_ff <= S_DATA;
          tx_bc_ff <= {1'b1, wlen};  // Length minus one: wlen plus four.
        end
        S_DATA: if (tx_bit_end) begin
          tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
          tx_bc_ff <= tx_bc_ff - 3'h0001;
          if (tx_bc_ff == '0) begin
            tx_st_ff    <= lc_ff[uart_pkg::LC_PEN] ? S_PAR : S_STOP;
            tx_stop2_ff <= lc_ff[uart_pkg::LC_STP2];
          end
        end
        S_PAR: if (tx_bit_end) tx_st_ff <= S_STOP;
        S_STOP: if (tx_bit_end) begin
          tx_stop2_ff <= 1'b0;
          if (!tx_stop2_ff) tx_st_ff <= S_IDLE;
        end
        default: tx_st_ff <= S_IDLE;
      endcase
    end
  end

  // Receiver: pin synchroniser, loopback select and character assembly.
  logic        rx_m_ff;     // First synchroniser stage, read only by the second.
  logic        rx_s_ff;     // Synchronised pin.
  logic        rx_line;
  ser_state_e  rx_st_ff;
  logic [3:0]  rx_tc_ff;
  logic [2:0]  rx_bc_ff;
  logic [7:0]  rx_sh_ff;
  logic        rx_par_ff;   // Sampled parity bit.
  logic        ovr_ff;      // Overrun pending for the next stored entry.
  logic        rx_samp;
  logic [7:0]  rx_byte;
  logic        rx_pe;
  logic        rx_be;
  logic        rx_done;

  assign rx_line  = ct_ff[uart_pkg::CT_LBE] ? SERIAL_TRANSMIT_LINE : rx_s_ff;
  assign rx_samp  = tick && (rx_tc_ff == uart_pkg::LAST_TICK);
  assign rx_byte  = rx_sh_ff >> (2'h3 - wlen);
  assign rx_pe    = lc_ff[uart_pkg::LC_PEN] &&
                    (rx_par_ff != parity_of(rx_byte, wlen, lc_ff[uart_pkg::LC_EPS],
                                            lc_ff[uart_pkg::LC_SPS]));
  assign rx_be    = (rx_byte == '0) && !rx_line &&
                    !(lc_ff[uart_pkg::LC_PEN] && rx_par_ff);
  assign rx_done  = (rx_st_ff == S_STOP) && rx_samp;
  // A character arriving with the FIFO full is dropped and only marks overrun.
  assign rxf.push  = rx_done && !rxf.full;
  assign rxf.wdata = {ovr_ff, rx_be, rx_pe, !rx_line, rx_byte};
  assign rxf.pop   = RX_RD && !rxf.empty;

  // A low line in idle starts the count; a start still low at tick eight is kept.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_m_ff   <= 1'b1;
      rx_s_ff   <= 1'b1;
      rx_st_ff  <= S_IDLE;
      rx_tc_ff  <= '0;
      rx_bc_ff  <= '0;
      rx_sh_ff  <= '0;
      rx_par_ff <= 1'b0;
    end else begin
      rx_m_ff <= SERIAL_RECEIVE_LINE;
      rx_s_ff <= rx_m_ff;
      if (tick) rx_tc_ff <= rx_tc_ff + 4'h0001;
      case (rx_st_ff)
        S_IDLE: if (en_rx && !rx_line) begin
          rx_st_ff <= S_START;
          rx_tc_ff <= '0;
        end
        S_START: if (tick && rx_tc_ff == uart_pkg::START_TICK) begin
          rx_st_ff <= rx_line ? S_IDLE : S_DATA;
          rx_tc_ff <= '0;
          rx_bc_ff <= {1'b1, wlen};  // Length minus one: wlen plus four.
        end
        S_DATA: if (rx_samp) begin
          rx_sh_ff <= {rx_line, rx_sh_ff[7:1]};
          rx_bc_ff <= rx_bc_ff - 3'h0001;
          if (rx_bc_ff == '0) rx_st_ff <= lc_ff[uart_pkg::LC_PEN] ? S_PAR : S_STOP;
        end
        S_PAR: if (rx_samp) begin
          rx_par_ff <= rx_line;
          rx_st_ff  <= S_STOP;
        end
        S_STOP: if (rx_samp) begin
          rx_par_ff <= 1'b0;
          rx_st_ff  <= S_IDLE;
        end
        default: rx_st_ff <= S_IDLE;
      endcase
    end
  end

  // Receive timeout: counts ticks since the last stored character.
  logic [9:0] to_cnt_ff;
  logic       to_hit;
  assign to_hit = tick && !rxf.empty && (to_cnt_ff == uart_pkg::TOUT_TICKS);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      to_cnt_ff <= '0;
    end else if (rxf.push || rxf.empty) begin
      to_cnt_ff <= '0;
    end else if (tick && to_cnt_ff != uart_pkg::TOUT_TICKS) begin
      to_cnt_ff <= to_cnt_ff + 10'h0001;
    end
  end

  // Event sources; a set in the same cycle as a clear wins.
  logic [6:0] ev_set;
  logic       tx_lvl;
  logic       rx_lvl;
  assign tx_lvl = lc_ff[uart_pkg::LC_FEN] ? (txf.count <= level_of(ifls_ff[2:0]))
                                          : txf.empty;
  assign rx_lvl = lc_ff[uart_pkg::LC_FEN] ? (rxf.count >= level_of(ifls_ff[5:3]))
                                          : !rxf.empty;
  always_comb begin
    ev_set                    = '0;
    ev_set[uart_pkg::EV_RX]   = rx_lvl;
    ev_set[uart_pkg::EV_TX]   = tx_lvl;
    ev_set[uart_pkg::EV_RT]   = to_hit;
    ev_set[uart_pkg::EV_FE]   = rxf.push && rxf.wdata[uart_pkg::RX_FE];
    ev_set[uart_pkg::EV_PE]   = rxf.push && rxf.wdata[uart_pkg::RX_PE];
    ev_set[uart_pkg::EV_BE]   = rxf.push && rxf.wdata[uart_pkg::RX_BE];
    ev_set[uart_pkg::EV_OE]   = rx_done && rxf.full;
    nxt_raw                   = (raw_ff & ~(EVENT_CLR_WR ? EVENT_CLR_DATA : 7'h0000))
                                | ev_set;
    if (rxf.empty) nxt_raw[uart_pkg::EV_RT] = 1'b0;
  end

  // Raw events, overrun bookkeeping and registered status outputs.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      raw_ff        <= '0;
      ovr_ff        <= 1'b0;
      OVERRUN       <= 1'b0;
      SERIAL_TRANSMIT_LINE <= 1'b1;
      RX_DATA       <= '0;
      BUSY          <= 1'b0;
      TX_EMPTY      <= 1'b1;
      TX_FULL       <= 1'b0;
      RX_EMPTY      <= 1'b1;
      RX_FULL       <= 1'b0;
      RAW_STATUS    <= '0;
      MASKED_STATUS <= '0;
      IRQ           <= 1'b0;
    end else begin
      raw_ff <= nxt_raw;
      if (rx_done && rxf.full) ovr_ff <= 1'b1;
      else if (rxf.push) ovr_ff <= 1'b0;
      if (rx_done && rxf.full) OVERRUN <= 1'b1;
      else if (OVERRUN_CLR) OVERRUN <= 1'b0;
      // Break holds the line low regardless of the shifter.
      SERIAL_TRANSMIT_LINE <= tx_bit && !lc_ff[uart_pkg::LC_BRK];
      RX_DATA       <= rxf.rdata;
      BUSY          <= !txf.empty || (tx_st_ff != S_IDLE);
      TX_EMPTY      <= txf.empty;
      TX_FULL       <= txf.full;
      RX_EMPTY      <= rxf.empty;
      RX_FULL       <= rxf.full;
      RAW_STATUS    <= nxt_raw;
      MASKED_STATUS <= nxt_raw & mask_ff;
      IRQ           <= |(nxt_raw & mask_ff);
    end
  end
endmodule

/* File: verif/uart_sva.sv */
// Checker for the serial transceiver's status and transmit ports.
// Assumes one clock domain; it is bound to uart_top.
module uart_chk (
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       TX_WR,
  input wire logic       TX_FULL,
  input wire logic       TX_EMPTY,
  input wire logic       BUSY,
  input wire logic       RX_FULL,
  input wire logic       RX_EMPTY,
  input wire logic       OVERRUN,
  input wire logic       SERIAL_TRANSMIT_LINE,
  input wire logic [6:0] RAW_STATUS,
  input wire logic [6:0] MASKED_STATUS,
  input wire logic       IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_irq; IRQ == |MASKED_STATUS; endproperty
  a_irq: assert property (p_irq) else $error("irq not or of masked");
  property p_msk; (MASKED_STATUS & ~RAW_STATUS) == 7'h00; endproperty
  a_msk: assert property (p_msk) else $error("masked not within raw");
  property p_busy; TX_WR && !TX_FULL |-> ##[1:2] BUSY; endproperty
  a_busy: assert property (p_busy) else $error("busy late");
  property p_bfall; $fell(BUSY) |-> TX_EMPTY; endproperty
  a_bfall: assert property (p_bfall) else $error("busy fell early");
  property p_txf; TX_FULL |-> !TX_EMPTY; endproperty
  a_txf: assert property (p_txf) else $error("tx full and empty");
  property p_rxf; RX_FULL |-> !RX_EMPTY; endproperty
  a_rxf: assert property (p_rxf) else $error("rx full and empty");
  property p_idle; !BUSY |-> SERIAL_TRANSMIT_LINE; endproperty
  a_idle: assert property (p_idle) else $error("line low when idle");
  property p_ovr; $rose(OVERRUN) |-> RX_FULL; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun without full");
  c_busy: cover property ($rose(BUSY));
  c_ovr: cover property ($rose(OVERRUN));
  c_irq: cover property ($rose(IRQ));
endmodule
bind uart_top uart_chk u_chk (.CORE_CLK, .RST_N, .TX_WR, .TX_FULL, .TX_EMPTY, .BUSY,
  .RX_FULL, .RX_EMPTY, .OVERRUN, .SERIAL_TRANSMIT_LINE, .RAW_STATUS, .MASKED_STATUS, .IRQ);

/* File: verif/uart_peer.sv */
// Remote serial device: sends frames on the receive pin, collects transmit frames.
// Assumes eight data bits, no parity, one stop, BIT_CLKS core clocks a bit.
module uart_peer #(parameter int BIT_CLKS = 32) (
  input  wire logic CLK,
  input  wire logic LINE_IN,
  output logic      LINE_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];  // Bytes seen; a bad stop inverts them to force a mismatch.
  logic [7:0] b;       // Byte being assembled.
  initial LINE_OUT = 1'b1;
  // Send one frame; a low stop level lets a framing fault be made on purpose.
  task automatic send(input logic [7:0] v, input logic stp);
    logic [9:0] f;
    f = {stp, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK) #1 LINE_OUT = f[i];
      repeat (BIT_CLKS - 1) @(posedge CLK);
    end
    @(posedge CLK) #1 LINE_OUT = 1'b1;
    repeat (BIT_CLKS) @(posedge CLK);
  endtask
  // Sample each bit in its middle, starting from the falling start edge.
  initial forever begin
    @(negedge LINE_IN);
    repeat (BIT_CLKS / 2) @(posedge CLK);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge CLK);
      if (i < 8) b[i] = LINE_IN;
    end
    got.push_back(LINE_IN ? b : ~b);
  end
endmodule

/* File: verif/async_serial_transceiver_tb.sv */
// Bench for the serial transceiver: strobes its control ports, talks via a peer.
// Assumes divisor two, so a bit lasts 32 core clocks.
module async_serial_transceiver_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_n, rx_line, tx_line, busy, tx_empty, tx_full, rx_empty, rx_full;
  logic overrun, irq;
  logic [9:0] wr;          // One write strobe per control port.
  logic [15:0] d;          // Shared data for every strobe.
  logic [11:0] rx_data;
  logic [6:0] raw, masked;
  logic [11:0] q[$];       // Expected transmit bytes, then receive entries.
  logic [7:0] v;
  int error_cnt, compares, n, cyc;
  uart_peer #(.BIT_CLKS(32)) u_peer (.CLK(core_clk), .LINE_IN(tx_line), .LINE_OUT(rx_line));
  uart_top DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .SERIAL_RECEIVE_LINE(rx_line),
    .SERIAL_TRANSMIT_LINE(tx_line), .INT_DIV_WR(wr[0]), .INT_DIV_DATA(d),
    .FRAC_DIV_WR(wr[1]), .FRAC_DIV_DATA(d[5:0]), .LINE_CTRL_WR(wr[2]),
    .LINE_CTRL_DATA(d[7:0]), .CTRL_WR(wr[3]), .CTRL_DATA(d[3:0]), .LEVEL_SEL_WR(wr[4]),
    .LEVEL_SEL_DATA(d[5:0]), .MASK_WR(wr[5]), .MASK_DATA(d[6:0]), .EVENT_CLR_WR(wr[6]),
    .EVENT_CLR_DATA(d[6:0]), .TX_WR(wr[7]), .TX_DATA(d[7:0]), .RX_RD(wr[8]),
    .OVERRUN_CLR(wr[9]), .RX_DATA(rx_data), .BUSY(busy), .TX_EMPTY(tx_empty),
    .TX_FULL(tx_full), .RX_EMPTY(rx_empty), .RX_FULL(rx_full), .OVERRUN(overrun),
    .RAW_STATUS(raw), .MASKED_STATUS(masked), .IRQ(irq));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Hang guard: the tests need about 8200 cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One-cycle strobe on port k with data x.
  task automatic put(input int k, input logic [15:0] x);
    @(posedge core_clk) #1;
    wr[k] = 1'b1;
    d = x;
    @(posedge core_clk) #1;
    wr[k] = 1'b0;
  endtask
  task automatic complete_run;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wr = '0;
    d = '0;
    void'($urandom(73));
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk({busy, tx_empty, rx_empty}, 12'h003);
    put(0, 16'h0002);
    put(1, 16'h0000);
    put(2, 16'h0070);
    put(4, 16'h0000);
    put(5, 16'h007F);
    put(3, 16'h000D);
    for (int i = 0; i < 4; i++) begin
      q.push_back(12'($urandom_range(255)));
      put(7, 16'(q[i]));
    end
    chk(busy, 12'h001);
    for (n = 0; n < 3000 && u_peer.got.size() < 4; n++) @(posedge core_clk);
    repeat (40) @(posedge core_clk);
    chk(busy, 12'h000);
    chk(12'(u_peer.got.size()), 12'h004);
    foreach (u_peer.got[i]) chk(u_peer.got[i], q[i]);
    q.delete();
    for (int i = 0; i < 17; i++) begin
      v = 8'($urandom_range(255));
      if (i < 16) q.push_back({4'h0, v});
      u_peer.send(v, 1'b1);
    end
    chk({rx_full, overrun}, 12'h003);
    for (int i = 0; i < 16; i++) begin
      chk(rx_data, q[i]);
      put(8, 16'h0000);
      repeat (2) @(posedge core_clk);
    end
    chk(rx_empty, 12'h001);
    // Loopback: disable, turn loopback on, send one byte to ourselves.
    put(3, 16'h000C);
    put(3, 16'h000F);
    v = 8'($urandom_range(255));
    put(7, {8'h00, v});
    for (n = 0; n < 2000 && rx_empty; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    // The earlier dropped character marks the next stored entry with overrun.
    chk(rx_data, {4'h8, v});
    put(8, 16'h0000);
    put(3, 16'h000C);
    put(3, 16'h000D);
    u_peer.send(8'h5A, 1'b0);
    for (n = 0; n < 2000 && rx_empty; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk(rx_data, 12'h15A);
    put(6, 16'h0040);
    put(9, 16'h0000);
    chk({raw[6], overrun, masked[6]}, 12'h000);
    // Transmit FIFO empty is at or below its level, and every event is unmasked.
    chk({irq, raw[1], masked[1]}, 12'h007);
    complete_run();
  end
endmodule
